// file: bench/cbt_checker.sv
// Checker of decoder lengths, state counts and the software reset sequence.
`default_nettype none
module cbt_checker
   import cbt_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   input wire logic        dec_valid_in,
   input wire logic [7:0]  byte0_in,
   input wire logic [7:0]  byte1_in,
   input wire logic [7:0]  byte2_in,
   input wire logic        branch_taken_in,
   input wire logic        operand_ext_in,
   input wire logic        stack_ext_in,
   input wire logic [4:0]  shift_count_in,
   input wire logic        dec_done_out,
   input wire logic [2:0]  length_out,
   input wire logic [7:0]  states_out,
   input wire logic        signed_op_out,
   input wire logic        auto_inc_out,
   input wire logic        rel_valid_out,
   input wire logic [15:0] rel_disp_out,
   input wire logic        reset_low_n_out,
   input wire logic        core_reset_out,
   input wire logic        pc_load_out,
   input wire logic [15:0] pc_value_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // -----------------------------------------------------------------
   // Helper logic
   // -----------------------------------------------------------------
   logic [7:0] run_q;      // Cycles the reset sequence has run so far.
   logic       is_shift;   // First byte is a shift opcode.
   logic [7:0] shift_exp;  // Expected shift cost, floor applied.
   assign is_shift = byte0_in inside {8'h_08, 8'h_09, 8'h_0A, 8'h_0C,
                                      8'h_0D, 8'h_0E, 8'h_18, 8'h_19,
                                      8'h_1A};
   // A zero count still costs the full floor, not the base alone.
   assign shift_exp = (shift_count_in == 5'h00) ? 8'h_08
                                                : 8'h_07 + 8'(shift_count_in);
   // The length counter is read on the cycle the sequence ends.
   always_ff @(posedge clk_sys_in) begin
      run_q <= (rst_in || !core_reset_out) ? 8'h_00 : run_q + 8'h_01;
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   a_done_cause: assert property (
      dec_done_out |-> $past(dec_valid_in))
      else $error("done pulse without a request");
   a_cond_count: assert property (
      dec_valid_in && byte0_in[7:4] == 4'hD ##1 dec_done_out |->
      length_out == 3'h2 &&
      states_out == ($past(branch_taken_in) ? 8'h_08 : 8'h_04))
      else $error("conditional jump length or count wrong");
   a_bit_count: assert property (
      dec_valid_in && byte0_in[7:4] == 4'h3 ##1 dec_done_out |->
      length_out == 3'h3 &&
      states_out == ($past(branch_taken_in) ? 8'h_09 : 8'h_05))
      else $error("bit branch length or count wrong");
   a_loop_count: assert property (
      dec_valid_in && byte0_in == 8'h_E0 ##1 dec_done_out |->
      length_out == 3'h3 &&
      states_out == ($past(branch_taken_in) ? 8'h_09 : 8'h_05))
      else $error("loop branch length or count wrong");
   a_short_disp: assert property (
      dec_valid_in && byte0_in[7:4] == 4'h2 ##1 dec_done_out |->
      rel_valid_out && rel_disp_out == {{5{$past(byte0_in[2])}},
      $past(byte0_in[2:0]), $past(byte1_in)})
      else $error("short displacement wrong");
   a_shift_floor: assert property (
      dec_valid_in && is_shift ##1 dec_done_out |->
      states_out == $past(shift_exp))
      else $error("shift count wrong");
   a_low_span: assert property (
      $fell(reset_low_n_out) |->
      (!reset_low_n_out) [*6] ##1 reset_low_n_out)
      else $error("reset line low span wrong");
   a_seq_len: assert property (
      $fell(core_reset_out) |-> run_q == 8'h24)
      else $error("reset sequence length wrong");
   a_restart_pc: assert property (
      pc_load_out |-> pc_value_out == 16'h_2080 && $past(core_reset_out))
      else $error("restart load wrong");
   a_signed_pref: assert property (
      dec_valid_in && byte0_in == 8'h_FE &&
      byte1_in inside {8'h_6C, 8'h_8C} ##1 dec_done_out |->
      signed_op_out && length_out == 3'h4)
      else $error("signed prefix not honoured");
   // -----------------------------------------------------------------
   // Coverage of the main scenarios
   // -----------------------------------------------------------------
   c_seq_run: cover property (core_reset_out ##1 !core_reset_out);
   c_signed: cover property (dec_done_out && signed_op_out);
   c_b2b: cover property (dec_done_out ##1 dec_done_out);
endmodule
bind cbt_decoder cbt_checker i_chk (
   .clk_sys_in, .rst_in, .dec_valid_in, .byte0_in, .byte1_in, .byte2_in,
   .branch_taken_in, .operand_ext_in, .stack_ext_in, .shift_count_in,
   .dec_done_out, .length_out, .states_out, .signed_op_out, .auto_inc_out,
   .rel_valid_out, .rel_disp_out, .reset_low_n_out, .core_reset_out,
   .pc_load_out, .pc_value_out
);
`default_nettype wire

// file: bench/cbt_fetch_model.sv
// Fetch path model: presents instruction bytes and keeps a slave pc.
`default_nettype none
module cbt_fetch_model (
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        req_in,       // Bench asks for a fetch.
   input  wire logic [23:0] ins_in,       // Bytes 2..0 of the request.
   input  wire logic        done_in,      // Decode finished.
   input  wire logic [2:0]  len_in,       // Reported length.
   input  wire logic        load_in,      // Restart load.
   input  wire logic [15:0] load_val_in,  // Restart address.
   output logic             valid_out,
   output logic [23:0]      bytes_out,
   output logic [15:0]      pc_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [23:0] last_q;  // Last bytes presented.
   assign valid_out = req_in;
   // Idle bytes are inverted so that stale data can never pass as fresh.
   assign bytes_out = req_in ? ins_in : ~last_q;
   // The slave pc steps by the reported length, or takes the restart.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         last_q <= 24'h00_0000;
         pc_out <= 16'h_0000;
      end else begin
         if (req_in) last_q <= ins_in;
         if (load_in) pc_out <= load_val_in;
         else if (done_in) pc_out <= pc_out + 16'(len_in);
      end
   end
endmodule
`default_nettype wire

// file: bench/tb_cpu_branch_and_timing_decoder.sv
// Self-checking bench of the branch and timing decoder.
`default_nettype none
module tb_cpu_branch_and_timing_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] b0, b1;
      logic       tk, oe, se;
      logic [4:0] cnt;
      logic [2:0] len;
      logic [7:0] st;
   } cbt_row_type;
   // Ordinary cases: bytes, conditions, then expected length and states.
   cbt_row_type rows [16] = '{
      '{8'h_D7, 8'h_00, 1'b1, 1'b0, 1'b0, 5'h00, 3'h2, 8'h_08},
      '{8'h_DB, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h2, 8'h_04},
      '{8'h_30, 8'h_00, 1'b1, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_09},
      '{8'h_3F, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_05},
      '{8'h_E0, 8'h_00, 1'b1, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_09},
      '{8'h_E0, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_05},
      '{8'h_08, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_08},
      '{8'h_0E, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h05, 3'h3, 8'h_0C},
      '{8'h_19, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h01, 3'h3, 8'h_08},
      '{8'h_A2, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_06},
      '{8'h_A2, 8'h_03, 1'b0, 1'b1, 1'b0, 5'h00, 3'h3, 8'h_0C},
      '{8'h_A3, 8'h_00, 1'b0, 1'b1, 1'b0, 5'h00, 3'h4, 8'h_0B},
      '{8'h_EF, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h3, 8'h_0D},
      '{8'h_28, 8'h_00, 1'b0, 1'b0, 1'b1, 5'h00, 3'h2, 8'h_10},
      '{8'h_F0, 8'h_00, 1'b0, 1'b0, 1'b0, 5'h00, 3'h1, 8'h_0C},
      '{8'h_F0, 8'h_00, 1'b0, 1'b0, 1'b1, 5'h00, 3'h1, 8'h_10}};
   logic        clk_sys_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        branch_taken_in = 1'b0;
   logic        operand_ext_in = 1'b0;
   logic        stack_ext_in = 1'b0;
   logic [4:0]  shift_count_in = 5'h00;
   logic        req = 1'b0;
   logic [23:0] ins = 24'h00_0000;
   logic        dec_valid_in, dec_done_out, signed_op_out, auto_inc_out;
   logic        rel_valid_out, reset_low_n_out, core_reset_out, pc_load_out;
   logic [2:0]  length_out;
   logic [7:0]  states_out;
   logic [15:0] rel_disp_out, pc_value_out, pc, sum;
   logic [23:0] bytes;
   cbt_row_type r;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          n, lo;
   logic        dn;
   always #2 clk_sys_in = ~clk_sys_in;
   cbt_decoder i_dut (
      .clk_sys_in, .rst_in, .dec_valid_in, .byte0_in(bytes[7:0]),
      .byte1_in(bytes[15:8]), .byte2_in(bytes[23:16]), .branch_taken_in,
      .operand_ext_in, .stack_ext_in, .shift_count_in, .dec_done_out,
      .length_out, .states_out, .signed_op_out, .auto_inc_out,
      .rel_valid_out, .rel_disp_out, .reset_low_n_out, .core_reset_out,
      .pc_load_out, .pc_value_out);
   cbt_fetch_model i_fetch (
      .clk_sys_in, .rst_in, .req_in(req), .ins_in(ins),
      .done_in(dec_done_out), .len_in(length_out), .load_in(pc_load_out),
      .load_val_in(pc_value_out), .valid_out(dec_valid_in),
      .bytes_out(bytes), .pc_out(pc));
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen,
                        input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One fetch held for a single edge; the wait for done is bounded.
   task automatic run(input logic [23:0] w);
      @(posedge clk_sys_in);
      req <= 1'b1;
      ins <= w;
      @(posedge clk_sys_in);
      req <= 1'b0;
      #1;
      for (n = 0; n < 20 && dec_done_out !== 1'b1; n++) begin
         @(posedge clk_sys_in);
         #1;
      end
      if (n == 20) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      #1;
      check("rst_out", {dec_done_out, length_out, states_out,
            reset_low_n_out, core_reset_out, pc_load_out, rel_valid_out},
            16'h_0008);
      check("rst_pcv", pc_value_out, 16'h_2080);
      sum = 16'h_0000;
      foreach (rows[i]) begin
         r = rows[i];
         @(posedge clk_sys_in);
         branch_taken_in <= r.tk;
         operand_ext_in <= r.oe;
         stack_ext_in <= r.se;
         shift_count_in <= r.cnt;
         run({8'h_00, r.b1, r.b0});
         check("length", 16'(length_out), 16'(r.len));
         check("states", 16'(states_out), 16'(r.st));
         // Only the A-group rows, indirect and indexed, carry a mode byte worth looking at.
         if (r.b0[7:4] == 4'hA) begin
            check("ainc", 16'(auto_inc_out), 16'(r.b1[0]));
         end
         sum = sum + 16'(r.len);
      end
      @(posedge clk_sys_in);
      #1;
      check("slave_pc", pc, sum);
      run(24'h00_1024);
      check("disp_neg", rel_disp_out, 16'h_FC10);
      run(24'h00_FF2B);
      check("disp_pos", rel_disp_out, 16'h_03FF);
      check("rel_valid", 16'(rel_valid_out), 16'h_0001);
      // Prefixed and plain forms back to back; each result stands for
      // one cycle only, so each is looked at right after its own edge.
      @(posedge clk_sys_in);
      req <= 1'b1;
      ins <= 24'h00_8CFE;
      @(posedge clk_sys_in);
      ins <= 24'h00_108C;
      #1;
      check("b2b_sgn",
            16'({dec_done_out, signed_op_out, length_out}), 16'h_001C);
      @(posedge clk_sys_in);
      req <= 1'b0;
      #1;
      check("b2b_uns",
            16'({dec_done_out, signed_op_out, length_out}), 16'h_0013);
      // Software reset; a fetch offered in mid-sequence must be ignored.
      run(24'h00_00FF);
      check("sw_len", 16'(length_out), 16'h_0001);
      lo = 0;
      dn = 1'b0;
      for (n = 1; n < 100 && pc_load_out !== 1'b1; n++) begin
         @(posedge clk_sys_in);
         req <= (n == 9);
         ins <= 24'h00_00D7;
         #1;
         lo += int'(reset_low_n_out === 1'b0);
         dn |= (dec_done_out === 1'b1);
      end
      check("low_span", 16'(lo), 16'h_0006);
      check("refused", 16'(dn), 16'h_0000);
      check("seq_time", 16'(n >= 46 && n <= 54), 16'h_0001);
      @(posedge clk_sys_in);
      #1;
      check("restart", pc, 16'h_2080);
      print_verdict();
   end
endmodule
`default_nettype wire

// file: core/cbt_decoder.sv
// Branch and timing decoder: length, displacement, state counts, reset.
`default_nettype none
module cbt_decoder
   import cbt_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        dec_valid_in,      // Instruction bytes valid.
   input  wire logic [7:0]  byte0_in,          // First fetched byte.
   input  wire logic [7:0]  byte1_in,          // Second byte.
   input  wire logic [7:0]  byte2_in,          // Third byte.
   input  wire logic        branch_taken_in,   // Condition result.
   input  wire logic        operand_ext_in,    // Operand is external.
   input  wire logic        stack_ext_in,      // Stack is external.
   input  wire logic [4:0]  shift_count_in,    // Bits shifted.
   output logic             dec_done_out,      // Decode result pulse.
   output logic [2:0]       length_out,        // Total bytes.
   output logic [7:0]       states_out,        // Execution state times.
   output logic             signed_op_out,     // Signed mul/div.
   output logic             auto_inc_out,      // Odd mode byte.
   output logic             rel_valid_out,     // Displacement present.
   output logic [15:0]      rel_disp_out,      // Sign-extended offset.
   output logic             reset_low_n_out,   // Reset line, low active.
   output logic             core_reset_out,    // Reset sequence running.
   output logic             pc_load_out,       // Load restart address.
   output logic [15:0]      pc_value_out       // Restart address.
);
   // ------------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RS_IDLE,
      RS_PULL,
      RS_HOLD,
      RS_SEQ
   } cbt_rst_type;

   typedef struct packed {
      cbt_rst_type  rst;       // Software reset phase.
      logic [3:0]   rcnt;      // States left in the phase.
      logic         done;
      logic [2:0]   len;
      logic [7:0]   st;
      logic         sgn;
      logic         inc;
      logic         rv;
      logic [15:0]  disp;
      logic         rl_n;
      logic         crst;
      logic         pld;
   } cbt_dec_type;

   cbt_dec_type s_q;
   cbt_dec_type s_d;
   logic        tick;          // One pulse per state time.

   // Decoded opcode fields for the current fetch.
   logic [7:0]  op;
   logic [7:0]  mb;            // Byte after the opcode.
   logic [7:0]  nb;            // Third byte, byte2_in even after a prefix.
   logic        pre;

   // ------------------------------------------------------------------
   // State-time enable
   // ------------------------------------------------------------------
   cbt_state_tick #(
      .DIV (STATE_DIV)
   ) u_tick (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .tick_out   (tick)
   );

   // Picks the internal or external figure of a pair.
   function automatic logic [7:0] pick(input logic ext,
                                       input logic [7:0] a,
                                       input logic [7:0] b);
      pick = ext ? b : a;
   endfunction

   // Operand-mode bytes for the arithmetic/transfer groups, by low bits.
   function automatic logic [2:0] mode_len(input logic [1:0] m,
                                           input logic       odd);
      case (m)
         2'd0:    mode_len = 3'd3;                 // Direct.
         2'd1:    mode_len = 3'd4;                 // Immediate word.
         2'd2:    mode_len = 3'd3;                 // Indirect.
         default: mode_len = odd ? 3'd5 : 3'd4;    // Indexed.
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Prefix stripping
   // ------------------------------------------------------------------
   // The signed form shifts the opcode and mode bytes by one; the third byte is not shifted; the count is unchanged.
   always_comb begin
      pre = (byte0_in == OP_PREFIX_SIGNED);
      op  = pre ? byte1_in : byte0_in;
      mb  = pre ? byte2_in : byte1_in;
      nb  = byte2_in;
   end

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      logic [2:0] l;
      logic [7:0] t;
      logic [7:0] sh;
      l = 3'd1;
      t = ST_SIMPLE;
      sh = 8'(shift_count_in);
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.pld  = 1'b0;

      if (dec_valid_in && s_q.rst == RS_IDLE) begin
         s_d.rv  = 1'b0;
         s_d.sgn = 1'b0;
         s_d.inc = 1'b0;
         s_d.disp = '0;
         if (op[7:4] == OP_COND_BASE[7:4]) begin
            l = 3'd2;
            t = branch_taken_in ? ST_COND_TAKEN : ST_COND_NOT;
            s_d.rv = 1'b1;
            s_d.disp = {{8{mb[7]}}, mb};
         end else if (op[7:3] == OP_BITCLR_BASE[7:3] ||
                      op[7:3] == OP_BITSET_BASE[7:3]) begin
            l = 3'd3;
            t = branch_taken_in ? ST_BIT_TAKEN : ST_BIT_NOT;
            s_d.rv = 1'b1;
            s_d.disp = {{8{nb[7]}}, nb};
         end else if (op[7:3] == OP_SHORT_RELATIVE_JUMP_BASE[7:3] ||
                      op[7:3] == OP_SHORT_RELATIVE_CALL_BASE[7:3]) begin
            l = 3'd2;
            // Upper three bits from the opcode, low eight from the next.
            s_d.rv = 1'b1;
            s_d.disp = {{5{op[2]}}, op[2:0], mb};
            t = op[3] ? pick(stack_ext_in, ST_CALL_INT, ST_CALL_EXT)
                      : ST_JUMP;
         end else if (op == OP_LOOP) begin
            l = 3'd3;
            t = branch_taken_in ? ST_LOOP_TAKEN : ST_LOOP_NOT;
            s_d.rv = 1'b1;
            s_d.disp = {{8{nb[7]}}, nb};
         end else if (op == OP_LJMP || op == OP_LONG_RELATIVE_CALL) begin
            l = 3'd3;
            s_d.rv = 1'b1;
            s_d.disp = {nb, mb};
            t = (op == OP_LONG_RELATIVE_CALL)
                ? pick(stack_ext_in, ST_CALL_INT, ST_CALL_EXT)
                : ST_JUMP;
         end else if (op == OP_RET) begin
            t = pick(stack_ext_in, ST_RET_INT, ST_RET_EXT);
         end else if (op == OP_PUSHF) begin
            t = pick(stack_ext_in, ST_PUSHF_INT, ST_PUSHF_EXT);
         end else if (op == OP_POPF) begin
            t = pick(stack_ext_in, ST_POPF_INT, ST_POPF_EXT);
         end else if (op == OP_SWRESET) begin
            s_d.rst  = RS_PULL;
            s_d.rcnt = ST_RST_PULL;
            t = 8'(ST_RST_PULL + ST_RST_HOLD + ST_RST_SEQ);
         end else if (op == OP_NORM) begin
            l = 3'd3;
            t = 8'(ST_NORM_BASE + sh);
         end else if (op[7:5] == 3'b000 && op[3] && op[1:0] != 2'b11 &&
                      !(op[4] && op[2])) begin
            // Shift group 08..0A, 0C..0E, 18..1A; the double-word forms
            // at 0C..0E must not fall through to the register group.
            l = 3'd3;
            t = 8'(ST_SHIFT_BASE + sh);
            if (t < ST_SHIFT_MIN) begin
               t = ST_SHIFT_MIN;
            end
         end else if (op == OP_SKIP || op[7:4] <= 4'h_1) begin
            l = 3'd2;                                   // Single register.
         end else if (op[7:4] >= 4'h_4 && op[7:4] <= 4'h_C) begin
            // Two-operand forms; three-operand groups add a byte.
            l = mode_len(op[1:0], mb[0]);
            if (op[7:5] == 3'b010) begin
               l = 3'(l + 3'd1);
            end
            if (op[7:4] == 4'h_C && op[3]) begin
               l = 3'(l - 3'd1);                        // Push/pop.
            end
            if (op[1]) begin
               s_d.inc = mb[0];
               t = mb[0] ? pick(operand_ext_in, ST_INDP_INT, ST_INDP_EXT)
                         : pick(operand_ext_in, ST_IND_INT, ST_IND_EXT);
            end
            s_d.sgn = pre && (op[7:2] == OP_UNSIGNED_MULTIPLY_W2[7:2] ||
                              op[7:2] == OP_UNSIGNED_DIVIDE_W2[7:2]);
         end
         // The prefix byte is part of the instruction length.
         s_d.len  = pre ? 3'(l + 3'd1) : l;
         s_d.st   = t;
         s_d.done = 1'b1;
      end

      // Software reset phases advance on state-time ticks.
      if (tick && s_q.rst != RS_IDLE) begin
         if (s_q.rcnt > 4'h_1) begin
            s_d.rcnt = s_q.rcnt - 4'h_1;
         end else begin
            case (s_q.rst)
               RS_PULL: begin
                  s_d.rst  = RS_HOLD;
                  s_d.rcnt = ST_RST_HOLD;
               end
               RS_HOLD: begin
                  s_d.rst  = RS_SEQ;
                  s_d.rcnt = ST_RST_SEQ;
               end
               RS_SEQ: begin
                  s_d.rst = RS_IDLE;
                  s_d.pld = 1'b1;
               end
               default: s_d.rst = RS_IDLE;
            endcase
         end
      end
      // The line is low only during hold; it stays high during the pull phase.
      s_d.rl_n = !(s_d.rst == RS_HOLD);
      s_d.crst = (s_d.rst == RS_SEQ);
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_q      <= '0;
         s_q.rst  <= RS_IDLE;
         s_q.rl_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign dec_done_out    = s_q.done;
   assign length_out      = s_q.len;
   assign states_out      = s_q.st;
   assign signed_op_out   = s_q.sgn;
   assign auto_inc_out    = s_q.inc;
   assign rel_valid_out   = s_q.rv;
   assign rel_disp_out    = s_q.disp;
   assign reset_low_n_out = s_q.rl_n;
   assign core_reset_out  = s_q.crst;
   assign pc_load_out     = s_q.pld;
   assign pc_value_out    = RESTART_ADDR;
endmodule
`default_nettype wire

// file: core/cbt_pkg.sv
// Package of opcode codes, lengths and state counts for the decoder.
`default_nettype none
package cbt_pkg;
   // ------------------------------------------------------------------
   // Opcode values and masks
   // ------------------------------------------------------------------
   localparam logic [7:0] OP_PREFIX_SIGNED = 8'h_FE;   // Signed prefix.
   localparam logic [7:0] OP_SHORT_RELATIVE_JUMP_BASE     = 8'h_20;   // 20..27.
   localparam logic [7:0] OP_SHORT_RELATIVE_CALL_BASE    = 8'h_28;   // 28..2F.
   localparam logic [7:0] OP_BITCLR_BASE   = 8'h_30;   // 30..37.
   localparam logic [7:0] OP_BITSET_BASE   = 8'h_38;   // 38..3F.
   localparam logic [7:0] OP_COND_BASE     = 8'h_D0;   // D0..DF.
   localparam logic [7:0] OP_LOOP          = 8'h_E0;
   localparam logic [7:0] OP_LJMP          = 8'h_E7;
   localparam logic [7:0] OP_LONG_RELATIVE_CALL         = 8'h_EF;
   localparam logic [7:0] OP_RET           = 8'h_F0;
   localparam logic [7:0] OP_SWRESET       = 8'h_FF;
   localparam logic [7:0] OP_NORM          = 8'h_0F;
   localparam logic [7:0] OP_PUSHF         = 8'h_F2;
   localparam logic [7:0] OP_POPF          = 8'h_F3;
   localparam logic [7:0] OP_SKIP          = 8'h_00;
   localparam logic [7:0] OP_UNSIGNED_MULTIPLY_W2       = 8'h_6C;
   localparam logic [7:0] OP_UNSIGNED_DIVIDE_W2       = 8'h_8C;
   // ------------------------------------------------------------------
   // State counts
   // ------------------------------------------------------------------
   localparam logic [7:0] ST_COND_TAKEN    = 8'h_08;
   localparam logic [7:0] ST_COND_NOT      = 8'h_04;
   localparam logic [7:0] ST_BIT_TAKEN     = 8'h_09;
   localparam logic [7:0] ST_BIT_NOT       = 8'h_05;
   localparam logic [7:0] ST_LOOP_TAKEN    = 8'h_09;
   localparam logic [7:0] ST_LOOP_NOT      = 8'h_05;
   localparam logic [7:0] ST_JUMP          = 8'h_08;
   localparam logic [7:0] ST_CALL_INT      = 8'h_0D;   // 13.
   localparam logic [7:0] ST_CALL_EXT      = 8'h_10;   // 16.
   localparam logic [7:0] ST_RET_INT       = 8'h_0C;   // 12.
   localparam logic [7:0] ST_RET_EXT       = 8'h_10;   // 16.
   localparam logic [7:0] ST_SHIFT_BASE    = 8'h_07;
   localparam logic [7:0] ST_SHIFT_MIN     = 8'h_08;
   localparam logic [7:0] ST_NORM_BASE     = 8'h_0B;   // 11.
   localparam logic [7:0] ST_SIMPLE        = 8'h_04;
   localparam logic [7:0] ST_IND_INT       = 8'h_06;
   localparam logic [7:0] ST_IND_EXT       = 8'h_0B;   // 11.
   localparam logic [7:0] ST_INDP_INT      = 8'h_07;
   localparam logic [7:0] ST_INDP_EXT      = 8'h_0C;   // 12.
   localparam logic [7:0] ST_PUSHF_INT     = 8'h_08;
   localparam logic [7:0] ST_PUSHF_EXT     = 8'h_0C;
   localparam logic [7:0] ST_POPF_INT      = 8'h_09;
   localparam logic [7:0] ST_POPF_EXT      = 8'h_0D;
   // ------------------------------------------------------------------
   // Software reset sequence
   // ------------------------------------------------------------------
   localparam logic [3:0] ST_RST_PULL      = 4'h_2;
   localparam logic [3:0] ST_RST_HOLD      = 4'h_2;
   localparam logic [3:0] ST_RST_SEQ       = 4'h_C;   // 12.
   localparam logic [15:0] RESTART_ADDR    = 16'h_2080;
   localparam int unsigned STATE_DIV       = 3;       // Clocks per state.
endpackage
`default_nettype wire

// file: core/cbt_state_tick.sv
// State-time divider giving a one-cycle enable per CPU state time.
`default_nettype none
module cbt_state_tick
   import cbt_pkg::*;
#(
   parameter int unsigned DIV = STATE_DIV
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_in,
   output logic      tick_out
);
   // ------------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------------
   // The count register is eight bits wide, so larger dividers cannot load.
   if (DIV < 1 || DIV > 255) begin : g_div_check
      $error("cbt_state_tick: DIV out of range");
   end

   typedef struct packed {
      logic [7:0] cnt;   // Cycles left in the current state time.
      logic       tick;  // Registered enable pulse.
   } cbt_tick_type;

   cbt_tick_type s_q;
   cbt_tick_type s_d;

   // Count down and pulse once on reaching zero.
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 8'h_00) begin
         s_d.cnt  = 8'(DIV - 1);
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt - 8'h_01;
      end
   end

   // Register the state.
   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;
endmodule
`default_nettype wire
